// *** hw/cfs_pkg.sv ***
// constants and types shared by the transceiver fault supervisor
package cfs_pkg;
	localparam logic [7:0] CFS_ADDR_FAULT_STATUS = 8'h76;
	localparam logic [7:0] CFS_ADDR_ANALOG_TRIM  = 8'h77;
	localparam logic [7:0] CFS_ADDR_OSC_CTRL     = 8'h78;
	localparam logic [7:0] CFS_ADDR_LOCK         = 8'h7C;
	localparam logic [7:0] CFS_ADDR_FAULT_TIME   = 8'h7D;
	localparam logic [7:0] CFS_RST_FAULT_STATUS  = 8'h80;
	localparam logic [7:0] CFS_RST_ANALOG_TRIM   = 8'h0F;
	localparam logic [7:0] CFS_RST_FAULT_TIME    = 8'hFF;
	localparam logic [7:0] CFS_RST_OSC_CTRL      = 8'h02;
	localparam logic [7:0] CFS_UNLOCK_KEY        = 8'hA6;
	localparam int         CFS_BIT_ENABLE        = 7;
	localparam int         CFS_BIT_THERMAL       = 5;
	localparam int         CFS_BIT_HI_PWR        = 4;
	localparam int         CFS_BIT_HI_GND        = 3;
	localparam int         CFS_BIT_LO_PWR        = 2;
	localparam int         CFS_BIT_LO_GND        = 1;
	localparam int         CFS_BIT_TOGETHER      = 0;
	localparam int         CFS_BIT_CRYSTAL_OSCILLATOR_EN       = 0;
	localparam int         CFS_BIT_INTERNAL_OSCILLATOR_EN       = 1;
	localparam int         CFS_BIT_STOP          = 2;
	// dominant time-out: 40 kbaud floor allows roughly 17 bit times
	localparam int         CFS_TDOM_US           = 425;
	localparam int         CFS_CLK_MHZ           = 100;
	localparam int         CFS_TDOM_CYCLES       = CFS_TDOM_US * CFS_CLK_MHZ;
	localparam int         CFS_FAULT_CNT_W       = 9;
	localparam int         CFS_TDOM_W            = 20;
	typedef enum logic [1:0] {
		CFS_TX_IDLE,
		CFS_TX_TIMING,
		CFS_TX_BLOCKED
	} cfs_tx_state_t;
endpackage : cfs_pkg

// *** hw/cfs_reg_if.sv ***
// status register write strobe and write data, used only inside the top
`timescale 1ns/10ps
interface cfs_reg_if;
	logic       wr_fault_status;
	logic [7:0] wr_data;
	modport master (output wr_fault_status, output wr_data);
	modport slave  (input  wr_fault_status, input  wr_data);
endinterface : cfs_reg_if

// *** hw/cfs_sync3.sv ***
// three-stage input synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
module cfs_sync3 (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic ce_in,
	input  wire logic rst_val_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic s1;
	logic s2;
	logic s3;
	logic q_x;
	logic agree;
	assign agree = (s2 == s3);
	// stages hold the input relative to its idle level, so reset stays a constant
	assign q_out = q_x ^ rst_val_in;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s1  <= 1'b0;
			s2  <= 1'b0;
			s3  <= 1'b0;
			q_x <= 1'b0;
		end else if (ce_in) begin
			s1 <= d_in ^ rst_val_in;
			s2 <= s1;
			s3 <= s2;
			if (agree) q_x <= s3;
		end
	end
endmodule : cfs_sync3

// *** hw/cfs_tol_counter.sv ***
// toleration counter in bit times for one persistent short condition
`timescale 1ns/10ps
module cfs_tol_counter
	import cfs_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       ce_in,
	input  wire logic       cond_in,
	input  wire logic       tick_in,
	input  wire logic       restart_in,
	input  wire logic [7:0] limit_in,
	output logic            expired_out
);
	logic [CFS_FAULT_CNT_W-1:0] cnt;
	logic [CFS_FAULT_CNT_W-1:0] target;
	assign target      = {1'b0, limit_in} + 9'h001;
	assign expired_out = cond_in && tick_in && (cnt + 9'h001 >= target);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt <= '0;
		end else if (ce_in) begin
			if (!cond_in || restart_in) cnt <= '0;
			else if (tick_in && cnt < target) cnt <= cnt + 9'h001;
		end
	end
endmodule : cfs_tol_counter

// *** hw/cfs_supervisor.sv ***
// CAN transceiver fault supervisor: dominant time-out, fault flags, trim and oscillator enables
// Notes on behaviour
// - long low on transmit input after receive falling edge disables transmitter
// - rising edge on transmit input clears the dominant time-out timer
// - with detection on, any fault keeps transceiver off until cleared and gone
// - status bit 7 is the fault detection enable, read and write
// - bit 5 shows thermal shutdown; any change raises thermal interrupt flag
// - bit 4 high-to-power after toleration; write 1 clears and restarts counter
// - bit 3 high-to-ground; write 1 clears
// - bit 2 low-to-power; write 1 clears
// - bit 1 low-to-ground after toleration; write 1 clears and restarts counter
// - bit 0 lines shorted together; write 1 clears
// - toleration time register writable only after lock key A6 written
// - toleration equals programmed count plus one bit times
// - analog trim register writable only after lock key A6 written
// - upper three bits of analog trim pick receiver bias current
// - regulator trim field resets to 011
// - hysteresis control bit zero enables hysteresis, one disables
// - thermal select zero picks low threshold, one picks high threshold
// - crystal oscillator disabled after reset, enable bit runs it unless stop mode
// - internal oscillator on unless stop mode or its enable cleared
`timescale 1ns/10ps
module cfs_supervisor
	import cfs_pkg::*;
(
	input  wire logic       MCLK_IN,
	input  wire logic       NRST_IN,
	input  wire logic       CE_IN,
	input  wire logic       REG_WR_IN,
	input  wire logic       REG_RD_IN,
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire logic [7:0] REG_WDATA_IN,
	output logic      [7:0] REG_RDATA_OUT,
	input  wire logic       TX_IN,
	input  wire logic       RX_IN,
	input  wire logic       BIT_TICK_IN,
	input  wire logic       HI_PWR_SHORT_IN,
	input  wire logic       HI_GND_SHORT_IN,
	input  wire logic       LO_PWR_SHORT_IN,
	input  wire logic       LO_GND_SHORT_IN,
	input  wire logic       LINES_SHORT_IN,
	input  wire logic       THERMAL_SHUTDOWN_IN,
	output logic            TX_ENABLE_OUT,
	output logic            THERMAL_INTERRUPT_FLAG_OUT,
	output logic      [2:0] RECEIVER_BIAS_SELECT_OUT,
	output logic      [2:0] REGULATOR_VOLTAGE_TRIM_OUT,
	output logic            HYSTERESIS_DISABLE_BIT_OUT,
	output logic            THERMAL_THRESHOLD_SELECT_OUT,
	output logic            CRYSTAL_OSC_ENABLE_OUT,
	output logic            INTERNAL_OSC_ENABLE_OUT
);
	logic tx_s;
	logic rx_s;
	logic hp_s;
	logic hg_s;
	logic lp_s;
	logic lg_s;
	logic sh_s;
	logic th_s;

	// tx and rx idle high, so their synchronisers leave reset at one: no false edge
	cfs_sync3 u_sync_tx (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b1),
		.d_in       (TX_IN),
		.q_out      (tx_s)
	);

	cfs_sync3 u_sync_rx (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b1),
		.d_in       (RX_IN),
		.q_out      (rx_s)
	);

	cfs_sync3 u_sync_hp (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (HI_PWR_SHORT_IN),
		.q_out      (hp_s)
	);

	cfs_sync3 u_sync_hg (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (HI_GND_SHORT_IN),
		.q_out      (hg_s)
	);

	cfs_sync3 u_sync_lp (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (LO_PWR_SHORT_IN),
		.q_out      (lp_s)
	);

	cfs_sync3 u_sync_lg (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (LO_GND_SHORT_IN),
		.q_out      (lg_s)
	);

	cfs_sync3 u_sync_sh (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (LINES_SHORT_IN),
		.q_out      (sh_s)
	);

	cfs_sync3 u_sync_th (
		.clk_in     (MCLK_IN),
		.nrst_in    (NRST_IN),
		.ce_in      (CE_IN),
		.rst_val_in (1'b0),
		.d_in       (THERMAL_SHUTDOWN_IN),
		.q_out      (th_s)
	);

	// register decode
	cfs_reg_if rif ();
	logic       unlocked;
	logic       wr_status;
	logic       wr_trim;
	logic       wr_time;
	logic       wr_lock;
	logic       wr_osc;
	assign wr_status = REG_WR_IN && (REG_ADDR_IN == CFS_ADDR_FAULT_STATUS);
	assign wr_trim   = REG_WR_IN && (REG_ADDR_IN == CFS_ADDR_ANALOG_TRIM) && unlocked;
	assign wr_time   = REG_WR_IN && (REG_ADDR_IN == CFS_ADDR_FAULT_TIME) && unlocked;
	assign wr_lock   = REG_WR_IN && (REG_ADDR_IN == CFS_ADDR_LOCK);
	assign wr_osc    = REG_WR_IN && (REG_ADDR_IN == CFS_ADDR_OSC_CTRL);
	assign rif.wr_fault_status = wr_status;
	assign rif.wr_data         = REG_WDATA_IN;

	// lock: open only while the key is the last value written
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) unlocked <= 1'b0;
		else if (CE_IN && wr_lock) unlocked <= (REG_WDATA_IN == CFS_UNLOCK_KEY);
	end

	logic [7:0] analog_trim_config;
	logic [7:0] fault_tolerance_count;
	logic [7:0] osc_ctrl;
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			analog_trim_config    <= CFS_RST_ANALOG_TRIM;
			fault_tolerance_count <= CFS_RST_FAULT_TIME;
			osc_ctrl              <= CFS_RST_OSC_CTRL;
		end else if (CE_IN) begin
			if (wr_trim) analog_trim_config <= REG_WDATA_IN;
			if (wr_time) fault_tolerance_count <= REG_WDATA_IN;
			if (wr_osc) osc_ctrl <= REG_WDATA_IN & 8'h07;
		end
	end

	// analog controls straight from the trim register
	assign RECEIVER_BIAS_SELECT_OUT     = analog_trim_config[7:5];
	assign REGULATOR_VOLTAGE_TRIM_OUT   = analog_trim_config[4:2];
	assign HYSTERESIS_DISABLE_BIT_OUT   = analog_trim_config[1];
	assign THERMAL_THRESHOLD_SELECT_OUT = analog_trim_config[0];
	assign CRYSTAL_OSC_ENABLE_OUT       = osc_ctrl[CFS_BIT_CRYSTAL_OSCILLATOR_EN] && !osc_ctrl[CFS_BIT_STOP];
	// glitch-free gating lives in the oscillator cell; this is a level gated from two register bits
	assign INTERNAL_OSC_ENABLE_OUT      = osc_ctrl[CFS_BIT_INTERNAL_OSCILLATOR_EN] && !osc_ctrl[CFS_BIT_STOP];

	// fault status
	logic fault_detect_enable;
	logic high_line_power_short_flag;
	logic high_line_ground_short_flag;
	logic low_line_power_short_flag;
	logic low_line_ground_short_flag;
	logic lines_shorted_together_flag;
	logic thermal_prev;
	logic thermal_interrupt_flag;
	logic hp_expired;
	logic lg_expired;
	logic restart_hp;
	logic restart_lg;
	logic [4:0] clr;
	assign clr        = rif.wr_fault_status ? rif.wr_data[4:0] : 5'h00;
	assign restart_hp = clr[CFS_BIT_HI_PWR];
	assign restart_lg = clr[CFS_BIT_LO_GND];

	// only these two faults wait out the toleration time; the others set at once
	cfs_tol_counter u_tol_hp (
		.clk_in      (MCLK_IN),
		.nrst_in     (NRST_IN),
		.ce_in       (CE_IN),
		.cond_in     (hp_s && fault_detect_enable),
		.tick_in     (BIT_TICK_IN),
		.restart_in  (restart_hp),
		.limit_in    (fault_tolerance_count),
		.expired_out (hp_expired)
	);

	cfs_tol_counter u_tol_lg (
		.clk_in      (MCLK_IN),
		.nrst_in     (NRST_IN),
		.ce_in       (CE_IN),
		.cond_in     (lg_s && fault_detect_enable),
		.tick_in     (BIT_TICK_IN),
		.restart_in  (restart_lg),
		.limit_in    (fault_tolerance_count),
		.expired_out (lg_expired)
	);

	logic set_hg;
	logic set_lp;
	logic set_sh;
	assign set_hg = hg_s && fault_detect_enable;
	assign set_lp = lp_s && fault_detect_enable;
	assign set_sh = sh_s && fault_detect_enable;

	// set wins over a clear in the same cycle
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			fault_detect_enable         <= CFS_RST_FAULT_STATUS[CFS_BIT_ENABLE];
			high_line_power_short_flag  <= 1'b0;
			high_line_ground_short_flag <= 1'b0;
			low_line_power_short_flag   <= 1'b0;
			low_line_ground_short_flag  <= 1'b0;
			lines_shorted_together_flag <= 1'b0;
		end else if (CE_IN) begin
			if (wr_status) fault_detect_enable <= REG_WDATA_IN[CFS_BIT_ENABLE];
			high_line_power_short_flag  <= hp_expired ||
				(high_line_power_short_flag && !clr[CFS_BIT_HI_PWR]);
			high_line_ground_short_flag <= set_hg ||
				(high_line_ground_short_flag && !clr[CFS_BIT_HI_GND]);
			low_line_power_short_flag   <= set_lp ||
				(low_line_power_short_flag && !clr[CFS_BIT_LO_PWR]);
			low_line_ground_short_flag  <= lg_expired ||
				(low_line_ground_short_flag && !clr[CFS_BIT_LO_GND]);
			lines_shorted_together_flag <= set_sh ||
				(lines_shorted_together_flag && !clr[CFS_BIT_TOGETHER]);
		end
	end

	// thermal: interrupt flag sticky until a status write clears it with bit 5
	logic thermal_change;
	assign thermal_change = (th_s != thermal_prev);
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			thermal_prev           <= 1'b0;
			thermal_interrupt_flag <= 1'b0;
		end else if (CE_IN) begin
			thermal_prev           <= th_s;
			thermal_interrupt_flag <= thermal_change ||
				(thermal_interrupt_flag &&
				!(wr_status && REG_WDATA_IN[CFS_BIT_THERMAL]));
		end
	end
	assign THERMAL_INTERRUPT_FLAG_OUT = thermal_interrupt_flag;

	logic any_flag;
	logic fault_block;
	assign any_flag = high_line_power_short_flag | high_line_ground_short_flag |
		low_line_power_short_flag | low_line_ground_short_flag |
		lines_shorted_together_flag;
	logic any_short;
	logic fault_hold;
	assign any_short = hp_s | hg_s | lp_s | lg_s | sh_s;

	// a cleared toleration flag restarts its count, so hold off until the short is gone
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) fault_hold <= 1'b0;
		else if (CE_IN) fault_hold <= (any_flag || fault_hold) && any_short;
	end
	assign fault_block = fault_detect_enable && (any_flag || fault_hold);

	// dominant time-out
	cfs_tx_state_t              tx_state;
	cfs_tx_state_t              next_tx_state;
	logic [CFS_TDOM_W-1:0]      dom_cnt;
	logic                       tx_prev;
	logic                       rx_prev;
	logic                       rx_fall;
	logic                       tx_rise;
	logic                       dom_expired;
	assign rx_fall     = rx_prev && !rx_s;
	assign tx_rise     = !tx_prev && tx_s;
	assign dom_expired = (dom_cnt >= CFS_TDOM_W'(CFS_TDOM_CYCLES - 1));

	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			CFS_TX_IDLE:    if (rx_fall && !tx_s) next_tx_state = CFS_TX_TIMING;
			CFS_TX_TIMING: begin
				if (tx_rise || tx_s) next_tx_state = CFS_TX_IDLE;
				else if (dom_expired) next_tx_state = CFS_TX_BLOCKED;
			end
			CFS_TX_BLOCKED: if (tx_rise) next_tx_state = CFS_TX_IDLE;
			default:        next_tx_state = CFS_TX_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			tx_state <= CFS_TX_IDLE;
			dom_cnt  <= '0;
			tx_prev  <= 1'b1;
			rx_prev  <= 1'b1;
		end else if (CE_IN) begin
			tx_state <= next_tx_state;
			tx_prev  <= tx_s;
			rx_prev  <= rx_s;
			if (next_tx_state != CFS_TX_TIMING) dom_cnt <= '0;
			else dom_cnt <= dom_cnt + CFS_TDOM_W'(1);
		end
	end

	// transmitter enable: registered so it never glitches
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) TX_ENABLE_OUT <= 1'b0;
		else if (CE_IN) TX_ENABLE_OUT <= (next_tx_state != CFS_TX_BLOCKED) && !fault_block &&
			!th_s;
	end

	// read mux
	logic [7:0] status_rd;
	logic [7:0] rd_mux;
	assign status_rd = {fault_detect_enable, 1'b0, th_s, high_line_power_short_flag,
		high_line_ground_short_flag, low_line_power_short_flag,
		low_line_ground_short_flag, lines_shorted_together_flag};
	assign rd_mux = (REG_ADDR_IN == CFS_ADDR_FAULT_STATUS) ? status_rd :
		(REG_ADDR_IN == CFS_ADDR_ANALOG_TRIM) ? analog_trim_config :
		(REG_ADDR_IN == CFS_ADDR_FAULT_TIME)  ? fault_tolerance_count :
		(REG_ADDR_IN == CFS_ADDR_OSC_CTRL)    ? osc_ctrl :
		(REG_ADDR_IN == CFS_ADDR_LOCK)        ? {7'h00, unlocked} : 8'h00;

	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) REG_RDATA_OUT <= 8'h00;
		else if (CE_IN && REG_RD_IN) REG_RDATA_OUT <= rd_mux;
	end
endmodule : cfs_supervisor

// *** tb/cfs_bus_model.sv ***
// bit tick source and bus-line short emulation facing the supervisor
`timescale 1ns/10ps
module cfs_bus_model #(
	parameter int TICK_PERIOD = 8
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic [4:0] fault_req_in,
	output logic            tick_out,
	output logic      [4:0] short_out
);
	logic [7:0] tick_cnt;
	wire        wrap = (tick_cnt == 8'(TICK_PERIOD - 1));
	// eight cycles a bit is far above the slowest rate the time-out allows
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt <= 8'h00;
			tick_out <= 1'b0;
		end else begin
			tick_cnt <= wrap ? 8'h00 : tick_cnt + 8'h01;
			tick_out <= wrap;
		end
	end
	assign short_out = fault_req_in;
endmodule : cfs_bus_model

// *** tb/cfs_supervisor_checker.sv ***
// concurrent checks on the supervisor's ports
`timescale 1ns/10ps
module cfs_supervisor_checker
	import cfs_pkg::*;
(
	input  wire logic       MCLK_IN,
	input  wire logic       NRST_IN,
	input  wire logic       CE_IN,
	input  wire logic       REG_WR_IN,
	input  wire logic       REG_RD_IN,
	input  wire logic [7:0] REG_ADDR_IN,
	input  wire logic [7:0] REG_RDATA_OUT,
	input  wire logic       TX_IN,
	input  wire logic       RX_IN,
	input  wire logic       THERMAL_SHUTDOWN_IN,
	input  wire logic       TX_ENABLE_OUT,
	input  wire logic       THERMAL_INTERRUPT_FLAG_OUT,
	input  wire logic [2:0] RECEIVER_BIAS_SELECT_OUT,
	input  wire logic [2:0] REGULATOR_VOLTAGE_TRIM_OUT,
	input  wire logic       CRYSTAL_OSC_ENABLE_OUT
);
	logic        armed;
	logic [16:0] dom_cnt;
	wire         rd_go   = CE_IN && REG_RD_IN;
	wire         trim_wr = CE_IN && REG_WR_IN && REG_ADDR_IN == CFS_ADDR_ANALOG_TRIM;
	wire         osc_wr  = CE_IN && REG_WR_IN && REG_ADDR_IN == CFS_ADDR_OSC_CTRL;
	wire         mapped  = REG_ADDR_IN inside {8'h76, 8'h77, 8'h78, 8'h7C, 8'h7D};
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!NRST_IN);
	// margin covers the input synchronisers
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			armed   <= 1'b0;
			dom_cnt <= 17'h00000;
		end else begin
			armed   <= !TX_IN && (armed || $fell(RX_IN));
			dom_cnt <= (!armed || TX_IN) ? 17'h00000 : dom_cnt + 17'h00001;
		end
	end
	chk_dom_trip: assert property (int'(dom_cnt) > CFS_TDOM_CYCLES + 16 |-> !TX_ENABLE_OUT)
		else $error("transmitter still enabled after dominant time-out");
	chk_unmapped_read: assert property (rd_go && !mapped |=> REG_RDATA_OUT == 8'h00)
		else $error("unmapped read returned nonzero");
	chk_rdata_hold: assert property (!rd_go |=> $stable(REG_RDATA_OUT))
		else $error("read data changed without a read");
	chk_status_gap: assert property (rd_go && REG_ADDR_IN == CFS_ADDR_FAULT_STATUS |=> !REG_RDATA_OUT[6])
		else $error("reserved status bit reads one");
	chk_trim_hold: assert property (!trim_wr |=> $stable({RECEIVER_BIAS_SELECT_OUT, REGULATOR_VOLTAGE_TRIM_OUT}))
		else $error("trim outputs moved without a trim write");
	chk_osc_hold: assert property (!osc_wr |=> $stable(CRYSTAL_OSC_ENABLE_OUT))
		else $error("crystal enable moved without a write");
	chk_therm_flag: assert property ($rose(THERMAL_SHUTDOWN_IN) |-> ##[1:8] THERMAL_INTERRUPT_FLAG_OUT)
		else $error("thermal flag not raised");
	chk_therm_txoff: assert property (THERMAL_SHUTDOWN_IN [*8] |-> !TX_ENABLE_OUT)
		else $error("transmitter enabled during thermal shutdown");
	cov_trim_wr: cover property (trim_wr);
	cov_dom_trip: cover property (int'(dom_cnt) > CFS_TDOM_CYCLES + 16);
	cov_tx_off: cover property ($fell(TX_ENABLE_OUT));
endmodule : cfs_supervisor_checker
bind cfs_supervisor cfs_supervisor_checker u_chk (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
	.CE_IN(CE_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .TX_IN(TX_IN), .RX_IN(RX_IN),
	.THERMAL_SHUTDOWN_IN(THERMAL_SHUTDOWN_IN), .TX_ENABLE_OUT(TX_ENABLE_OUT),
	.THERMAL_INTERRUPT_FLAG_OUT(THERMAL_INTERRUPT_FLAG_OUT),
	.RECEIVER_BIAS_SELECT_OUT(RECEIVER_BIAS_SELECT_OUT),
	.REGULATOR_VOLTAGE_TRIM_OUT(REGULATOR_VOLTAGE_TRIM_OUT),
	.CRYSTAL_OSC_ENABLE_OUT(CRYSTAL_OSC_ENABLE_OUT));

// *** tb/test_can_transceiver_fault_supervisor.sv ***
// self-checking bench for the transceiver fault supervisor
`timescale 1ns/10ps
module test_can_transceiver_fault_supervisor
	import cfs_pkg::*;
;
	logic       clk = 1'b0, nrst = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
	logic       tx = 1'b1, rx = 1'b1, hot = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, m;
	logic [4:0] freq = 5'h00, shorts;
	logic       tick, tx_en, tflag, hyst, tsel, xen, ien;
	logic [2:0] bias, rtrim;
	int         mismatches = 0, checks = 0, b;
	int         imm [3] = '{3, 2, 0};
	int         tol [2] = '{4, 1};
	logic [7:0] osc_wd [4] = '{8'h01, 8'h00, 8'h07, 8'h02};
	logic [7:0] osc_ex [4] = '{8'h02, 8'h00, 8'h00, 8'h01};
	always #5 clk = ~clk;
	cfs_bus_model #(.TICK_PERIOD(8)) u_bus (.clk_in(clk), .nrst_in(nrst), .fault_req_in(freq),
		.tick_out(tick), .short_out(shorts));
	cfs_supervisor u_dut (.MCLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce), .REG_WR_IN(wr),
		.REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.TX_IN(tx), .RX_IN(rx), .BIT_TICK_IN(tick), .HI_PWR_SHORT_IN(shorts[4]),
		.HI_GND_SHORT_IN(shorts[3]), .LO_PWR_SHORT_IN(shorts[2]),
		.LO_GND_SHORT_IN(shorts[1]), .LINES_SHORT_IN(shorts[0]),
		.THERMAL_SHUTDOWN_IN(hot), .TX_ENABLE_OUT(tx_en), .THERMAL_INTERRUPT_FLAG_OUT(tflag),
		.RECEIVER_BIAS_SELECT_OUT(bias), .REGULATOR_VOLTAGE_TRIM_OUT(rtrim),
		.HYSTERESIS_DISABLE_BIT_OUT(hyst), .THERMAL_THRESHOLD_SELECT_OUT(tsel),
		.CRYSTAL_OSC_ENABLE_OUT(xen), .INTERNAL_OSC_ENABLE_OUT(ien));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd_chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// run is about 73k cycles; limit leaves headroom
	initial begin
		#900000;
		mismatches++;
		wrap_up();
	end
	initial begin
		cyc(20);
		nrst = 1'b1;
		rd_chk(8'h76, 8'h80);
		rd_chk(8'h77, 8'h0F);
		rd_chk(8'h7D, 8'hFF);
		rd_chk(8'h78, 8'h02);
		rd_chk(8'h50, 8'h00);
		chk({bias, rtrim, hyst, tsel}, 8'h0F);
		$display("test reset_values done");
		wr_reg(8'h7D, 8'h10);
		rd_chk(8'h7D, 8'hFF);
		wr_reg(8'h77, 8'h00);
		rd_chk(8'h77, 8'h0F);
		wr_reg(8'h7C, 8'hA6);
		wr_reg(8'h7D, 8'h02);
		rd_chk(8'h7D, 8'h02);
		wr_reg(8'h77, 8'h93);
		chk({bias, rtrim, hyst, tsel}, 8'h93);
		wr_reg(8'h77, 8'h60);
		chk({bias, rtrim, hyst, tsel}, 8'h60);
		wr_reg(8'h7C, 8'h00);
		wr_reg(8'h77, 8'hFF);
		rd_chk(8'h77, 8'h60);
		$display("test lock_and_trim done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(8'h78, osc_wd[i]);
			chk({6'h00, xen, ien}, osc_ex[i]);
		end
		// clock enable low must freeze the register file
		ce = 1'b0;
		wr_reg(8'h78, 8'h03);
		ce = 1'b1;
		rd_chk(8'h78, 8'h02);
		$display("test oscillators done");
		foreach (imm[i]) begin
			b = imm[i];
			m = 8'h80 | (8'h01 << b);
			freq[b] = 1'b1;
			cyc(8);
			chk(8'(tx_en), 8'h00);
			freq[b] = 1'b0;
			cyc(8);
			wr_reg(8'h76, 8'h80);
			rd_chk(8'h76, m);
			chk(8'(tx_en), 8'h00);
			wr_reg(8'h76, m);
			rd_chk(8'h76, 8'h80);
			chk(8'(tx_en), 8'h01);
		end
		// count of 2 means three ticks, eight cycles apart
		foreach (tol[i]) begin
			b = tol[i];
			m = 8'h80 | (8'h01 << b);
			freq[b] = 1'b1;
			cyc(14);
			rd_chk(8'h76, 8'h80);
			cyc(20);
			rd_chk(8'h76, m);
			wr_reg(8'h76, m);
			rd_chk(8'h76, 8'h80);
			chk(8'(tx_en), 8'h00);
			cyc(30);
			rd_chk(8'h76, m);
			freq[b] = 1'b0;
			cyc(8);
			wr_reg(8'h76, m);
			rd_chk(8'h76, 8'h80);
			chk(8'(tx_en), 8'h01);
		end
		$display("test fault_flags done");
		wr_reg(8'h76, 8'h00);
		freq[0] = 1'b1;
		cyc(10);
		rd_chk(8'h76, 8'h00);
		chk(8'(tx_en), 8'h01);
		freq[0] = 1'b0;
		// let the synchronised short drop before detection is turned back on
		cyc(8);
		wr_reg(8'h76, 8'h80);
		hot = 1'b1;
		cyc(8);
		rd_chk(8'h76, 8'hA0);
		chk({6'h00, tflag, tx_en}, 8'h02);
		wr_reg(8'h76, 8'hA0);
		chk(8'(tflag), 8'h00);
		hot = 1'b0;
		cyc(8);
		rd_chk(8'h76, 8'h80);
		chk({6'h00, tflag, tx_en}, 8'h03);
		wr_reg(8'h76, 8'hA0);
		chk(8'(tflag), 8'h00);
		$display("test enable_and_thermal done");
		tx = 1'b0;
		cyc(4);
		rx = 1'b0;
		cyc(30000);
		tx = 1'b1;
		rx = 1'b1;
		cyc(4);
		tx = 1'b0;
		cyc(4);
		rx = 1'b0;
		cyc(30000);
		chk(8'(tx_en), 8'h01);
		cyc(12520);
		chk(8'(tx_en), 8'h00);
		tx = 1'b1;
		rx = 1'b1;
		cyc(8);
		chk(8'(tx_en), 8'h01);
		$display("test dominant_timeout done");
		wrap_up();
	end
endmodule : test_can_transceiver_fault_supervisor
